//--- rtl/sfb_pkg.sv
`default_nettype none

package sfb_pkg;

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam int ADDR_W     = 24;
	localparam int SECTOR_LSB = 12;
	localparam int HALF_LSB   = 15;
	localparam int BLOCK_LSB  = 16;
	localparam int BIG_LSB    = 20;

	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_READ      = 8'h03;
	localparam logic [7:0] OP_FAST      = 8'h0b;
	localparam logic [7:0] OP_DUAL_OUT  = 8'h3b;
	localparam logic [7:0] OP_DUAL_IO   = 8'hbb;
	localparam logic [7:0] OP_DUAL_ID   = 8'h92;
	localparam logic [7:0] OP_QUAD_OUT  = 8'h6b;
	localparam logic [7:0] OP_QUAD_IO   = 8'heb;
	localparam logic [7:0] OP_QUAD_WORD = 8'he7;
	localparam logic [7:0] OP_QUAD_ID   = 8'h94;
	localparam logic [7:0] OP_QUAD_PP   = 8'h32;
	localparam logic [7:0] OP_PP        = 8'h02;
	localparam logic [7:0] OP_SE        = 8'h20;
	localparam logic [7:0] OP_BE32      = 8'h52;
	localparam logic [7:0] OP_BE64      = 8'hd8;

	// ----------------------------------------------------------------
	// clock counts per phase
	// ----------------------------------------------------------------
	localparam logic [5:0] OPC_CLKS     = 6'h08;
	localparam logic [5:0] ADDR_CLKS_1  = 6'h18;
	localparam logic [5:0] ADDR_CLKS_2  = 6'h0c;
	localparam logic [5:0] ADDR_CLKS_4  = 6'h06;
	localparam logic [5:0] DUMMY_FAST   = 6'h08;
	localparam logic [5:0] DUMMY_DUALIO = 6'h04;
	localparam logic [5:0] DUMMY_QUADIO = 6'h06;
	localparam logic [5:0] DUMMY_QWORD  = 6'h04;
	localparam logic [5:0] DUMMY_NONE   = 6'h00;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] LANE_OE_RST = 4'h0;
	localparam logic [3:0] LANE_O_RST  = 4'h0;
	localparam logic [2:0] SYNC_HI_RST = 3'h7;
	localparam logic [2:0] SYNC_LO_RST = 3'h0;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LANES1 = 3'b001,
		LANES2 = 3'b010,
		LANES4 = 3'b100
	} sfb_lanes_t;

	typedef enum logic [5:0] {
		ST_OPC    = 6'b000001,
		ST_ADDR   = 6'b000010,
		ST_DUMMY  = 6'b000100,
		ST_DOUT   = 6'b001000,
		ST_DIN    = 6'b010000,
		ST_IGNORE = 6'b100000
	} sfb_link_st_t;

endpackage : sfb_pkg

`default_nettype wire

//--- rtl/sfb_frontend.sv
`timescale 1ns/1ps
`default_nettype none

module sfb_frontend (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic [3:0] lane_i,
	output logic      [3:0] lane_o,
	output logic      [3:0] lane_oe,
	input  wire logic       por_active,
	input  wire logic       quad_enable,
	input  wire logic       write_busy,
	input  wire logic [7:0] rd_byte,
	output logic            cmd_valid,
	output logic      [7:0] cmd_opcode,
	output logic     [23:0] cmd_addr,
	output logic     [11:0] cmd_sector,
	output logic      [8:0] cmd_half_block,
	output logic      [7:0] cmd_block,
	output logic      [3:0] cmd_big_block,
	output logic            sel_active,
	output logic            standby,
	output logic            wp_protect_n
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		sfb_pkg::sfb_link_st_t st;
		sfb_pkg::sfb_lanes_t   lanes;
		logic [5:0]            cnt;
		logic [7:0]            opc;
		logic [23:0]           addr;
		logic                  hdr_valid;
	} sfb_rise_t;

	typedef struct packed {
		logic [3:0] lane_o;
		logic [3:0] lane_oe;
		logic [2:0] bitpos;
	} sfb_fall_t;

	typedef struct packed {
		logic [2:0]  cs_s;
		logic        cs_f;
		logic [2:0]  por_s;
		logic        por_f;
		logic [2:0]  hdr_s;
		logic        hdr_f;
		logic [2:0]  wp_s;
		logic        wp_f;
		logic        armed;
		logic        qe;
		logic [7:0]  rd;
		logic        cmd_valid;
		logic [7:0]  cmd_opc;
		logic [23:0] cmd_addr;
		logic [11:0] sector;
		logic [8:0]  half;
		logic [7:0]  block;
		logic [3:0]  big;
		logic        active;
		logic        standby;
		logic        wp_n;
	} sfb_core_t;

	sfb_rise_t r_q, r_d;
	sfb_fall_t f_q, f_d;
	sfb_core_t c_q, c_d;
	logic      frame_rst;

	// ----------------------------------------------------------------
	// opcode classification
	// ----------------------------------------------------------------
	function automatic sfb_pkg::sfb_lanes_t data_lanes(input logic [7:0] op);
		if (op == sfb_pkg::OP_DUAL_OUT || op == sfb_pkg::OP_DUAL_IO
				|| op == sfb_pkg::OP_DUAL_ID) begin
			return sfb_pkg::LANES2;
		end else if (op == sfb_pkg::OP_QUAD_OUT || op == sfb_pkg::OP_QUAD_IO
				|| op == sfb_pkg::OP_QUAD_WORD || op == sfb_pkg::OP_QUAD_ID
				|| op == sfb_pkg::OP_QUAD_PP) begin
			return sfb_pkg::LANES4;
		end else begin
			return sfb_pkg::LANES1;
		end
	endfunction : data_lanes
	function automatic sfb_pkg::sfb_lanes_t addr_lanes(input logic [7:0] op);
		if (op == sfb_pkg::OP_DUAL_IO || op == sfb_pkg::OP_DUAL_ID) begin
			return sfb_pkg::LANES2;
		end else if (op == sfb_pkg::OP_QUAD_IO || op == sfb_pkg::OP_QUAD_WORD
				|| op == sfb_pkg::OP_QUAD_ID) begin
			return sfb_pkg::LANES4;
		end else begin
			return sfb_pkg::LANES1;
		end
	endfunction : addr_lanes
	function automatic logic is_read(input logic [7:0] op);
		return op == sfb_pkg::OP_READ || op == sfb_pkg::OP_FAST
			|| op == sfb_pkg::OP_DUAL_OUT || op == sfb_pkg::OP_DUAL_IO
			|| op == sfb_pkg::OP_DUAL_ID || op == sfb_pkg::OP_QUAD_OUT
			|| op == sfb_pkg::OP_QUAD_IO || op == sfb_pkg::OP_QUAD_WORD
			|| op == sfb_pkg::OP_QUAD_ID;
	endfunction : is_read
	function automatic logic has_addr(input logic [7:0] op);
		return is_read(op) || op == sfb_pkg::OP_QUAD_PP || op == sfb_pkg::OP_PP
			|| op == sfb_pkg::OP_SE || op == sfb_pkg::OP_BE32
			|| op == sfb_pkg::OP_BE64;
	endfunction : has_addr
	function automatic logic [5:0] dummy_clks(input logic [7:0] op);
		if (op == sfb_pkg::OP_FAST || op == sfb_pkg::OP_DUAL_OUT
				|| op == sfb_pkg::OP_QUAD_OUT) begin
			return sfb_pkg::DUMMY_FAST;
		end else if (op == sfb_pkg::OP_DUAL_IO || op == sfb_pkg::OP_DUAL_ID) begin
			return sfb_pkg::DUMMY_DUALIO;
		end else if (op == sfb_pkg::OP_QUAD_IO || op == sfb_pkg::OP_QUAD_ID) begin
			return sfb_pkg::DUMMY_QUADIO;
		end else if (op == sfb_pkg::OP_QUAD_WORD) begin
			return sfb_pkg::DUMMY_QWORD;
		end else begin
			return sfb_pkg::DUMMY_NONE;
		end
	endfunction : dummy_clks
	function automatic logic [5:0] addr_clks(input sfb_pkg::sfb_lanes_t ln);
		case (ln)
			sfb_pkg::LANES2: return sfb_pkg::ADDR_CLKS_2;
			sfb_pkg::LANES4: return sfb_pkg::ADDR_CLKS_4;
			default:         return sfb_pkg::ADDR_CLKS_1;
		endcase
	endfunction : addr_clks

	// ----------------------------------------------------------------
	// link side, rising edge: opcode, address, phase tracking
	// ----------------------------------------------------------------
	// select high or no arming holds the link in reset, so a frame always
	// starts from opcode capture and a stopped clock leaves nothing hanging
	assign frame_rst = cs_n | ~c_q.armed;

	always_comb begin
		logic [7:0] op_n;
		op_n = {r_q.opc[6:0], lane_i[0]};
		r_d  = r_q;
		case (r_q.st)
			sfb_pkg::ST_OPC: begin
				r_d.opc = op_n;
				r_d.cnt = r_q.cnt + 6'h01;
				if (r_q.cnt == sfb_pkg::OPC_CLKS - 6'h01) begin
					r_d.cnt = 6'h00;
					if (data_lanes(op_n) == sfb_pkg::LANES4 && !c_q.qe) begin
						r_d.st = sfb_pkg::ST_IGNORE;
					end else if (has_addr(op_n)) begin
						r_d.st    = sfb_pkg::ST_ADDR;
						r_d.lanes = addr_lanes(op_n);
					end else begin
						r_d.st        = sfb_pkg::ST_DIN;
						r_d.hdr_valid = 1'b1;
					end
				end
			end
			sfb_pkg::ST_ADDR: begin
				case (r_q.lanes)
					sfb_pkg::LANES2: r_d.addr = {r_q.addr[21:0], lane_i[1:0]};
					sfb_pkg::LANES4: r_d.addr = {r_q.addr[19:0], lane_i[3:0]};
					default:         r_d.addr = {r_q.addr[22:0], lane_i[0]};
				endcase
				r_d.cnt = r_q.cnt + 6'h01;
				if (r_q.cnt == addr_clks(r_q.lanes) - 6'h01) begin
					r_d.cnt       = 6'h00;
					r_d.hdr_valid = 1'b1;
					r_d.lanes     = data_lanes(r_q.opc);
					if (!is_read(r_q.opc)) begin
						r_d.st = sfb_pkg::ST_DIN;
					end else if (dummy_clks(r_q.opc) == sfb_pkg::DUMMY_NONE) begin
						r_d.st = sfb_pkg::ST_DOUT;
					end else begin
						r_d.st = sfb_pkg::ST_DUMMY;
					end
				end
			end
			sfb_pkg::ST_DUMMY: begin
				r_d.cnt = r_q.cnt + 6'h01;
				if (r_q.cnt == dummy_clks(r_q.opc) - 6'h01) begin
					r_d.cnt = 6'h00;
					r_d.st  = sfb_pkg::ST_DOUT;
				end
			end
			default: begin
				r_d.st = r_q.st;
			end
		endcase
	end

	// opcode and address keep their value through reset so the core side
	// can still read them after the frame closes
	always_ff @(posedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			r_q.st        <= sfb_pkg::ST_OPC;
			r_q.lanes     <= sfb_pkg::LANES1;
			r_q.cnt       <= 6'h00;
			r_q.hdr_valid <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------------------------------
	// link side, falling edge: output lanes
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] sh;
		sh  = c_q.rd << f_q.bitpos;
		f_d = f_q;
		f_d.lane_oe = sfb_pkg::LANE_OE_RST;
		if (r_q.st == sfb_pkg::ST_DOUT) begin
			case (r_q.lanes)
				sfb_pkg::LANES2: begin
					f_d.lane_oe = 4'h3;
					f_d.lane_o  = {2'h0, sh[7:6]};
					f_d.bitpos  = f_q.bitpos + 3'h2;
				end
				sfb_pkg::LANES4: begin
					f_d.lane_oe = 4'hf;
					f_d.lane_o  = sh[7:4];
					f_d.bitpos  = f_q.bitpos + 3'h4;
				end
				default: begin
					f_d.lane_oe = 4'h2;
					f_d.lane_o  = {2'h0, sh[7], 1'b0};
					f_d.bitpos  = f_q.bitpos + 3'h1;
				end
			endcase
		end
	end

	always_ff @(negedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			f_q <= '{lane_o: sfb_pkg::LANE_O_RST, lane_oe: sfb_pkg::LANE_OE_RST,
				bitpos: 3'h0};
		end else begin
			f_q <= f_d;
		end
	end

	assign lane_o  = f_q.lane_o;
	assign lane_oe = f_q.lane_oe;

	// ----------------------------------------------------------------
	// core side
	// ----------------------------------------------------------------
	always_comb begin
		c_d = c_q;
		c_d.cs_s  = {c_q.cs_s[1:0], cs_n};
		c_d.por_s = {c_q.por_s[1:0], por_active};
		c_d.hdr_s = {c_q.hdr_s[1:0], r_q.hdr_valid};
		c_d.wp_s  = {c_q.wp_s[1:0], lane_i[2]};
		if (c_q.cs_s[1] == c_q.cs_s[2]) c_d.cs_f = c_q.cs_s[2];
		if (c_q.por_s[1] == c_q.por_s[2]) c_d.por_f = c_q.por_s[2];
		if (c_q.hdr_s[1] == c_q.hdr_s[2]) c_d.hdr_f = c_q.hdr_s[2];
		if (c_q.wp_s[1] == c_q.wp_s[2]) c_d.wp_f = c_q.wp_s[2];
		// arming needs select seen high, so a select low from power-up never starts
		if (c_q.por_f) begin
			c_d.armed = 1'b0;
		end else if (c_q.cs_f) begin
			c_d.armed = 1'b1;
		end
		// settings seen by the link only change while deselected
		if (c_q.cs_f) begin
			c_d.qe = quad_enable;
			c_d.rd = rd_byte;
		end
		c_d.cmd_valid = c_d.hdr_f && !c_q.hdr_f && c_q.armed;
		if (c_d.cmd_valid) begin
			c_d.cmd_opc  = r_q.opc;
			c_d.cmd_addr = r_q.addr;
			c_d.sector   = r_q.addr[sfb_pkg::ADDR_W-1:sfb_pkg::SECTOR_LSB];
			c_d.half     = r_q.addr[sfb_pkg::ADDR_W-1:sfb_pkg::HALF_LSB];
			c_d.block    = r_q.addr[sfb_pkg::ADDR_W-1:sfb_pkg::BLOCK_LSB];
			c_d.big      = r_q.addr[sfb_pkg::ADDR_W-1:sfb_pkg::BIG_LSB];
		end
		c_d.active  = !c_q.cs_f && c_q.armed && !c_q.por_f;
		c_d.standby = (c_q.cs_f || !c_q.armed) && !write_busy;
		// pin function is lost while it serves as a data lane
		c_d.wp_n = quad_enable ? 1'b1 : c_q.wp_f;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			c_q <= '0;
			c_q.cs_s  <= sfb_pkg::SYNC_HI_RST;
			c_q.cs_f  <= 1'b1;
			c_q.por_s <= sfb_pkg::SYNC_HI_RST;
			c_q.por_f <= 1'b1;
			c_q.hdr_s <= sfb_pkg::SYNC_LO_RST;
			c_q.wp_s  <= sfb_pkg::SYNC_HI_RST;
			c_q.wp_f  <= 1'b1;
			c_q.wp_n  <= 1'b1;
			c_q.standby <= 1'b1;
		end else begin
			c_q <= c_d;
		end
	end

	assign cmd_valid      = c_q.cmd_valid;
	assign cmd_opcode     = c_q.cmd_opc;
	assign cmd_addr       = c_q.cmd_addr;
	assign cmd_sector     = c_q.sector;
	assign cmd_half_block = c_q.half;
	assign cmd_block      = c_q.block;
	assign cmd_big_block  = c_q.big;
	assign sel_active     = c_q.active;
	assign standby        = c_q.standby;
	assign wp_protect_n   = c_q.wp_n;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_por_inhibit;
		@(posedge clk) disable iff (srst) c_q.por_f |=> !c_q.armed && !sel_active;
	endproperty
	a_por_inhibit: assert property (p_por_inhibit) else $error("armed under por");
	property p_arm_edge;
		@(posedge clk) disable iff (srst) $rose(c_q.armed) |-> $past(c_q.cs_f);
	endproperty
	a_arm_edge: assert property (p_arm_edge) else $error("armed while selected");
	property p_float;
		@(posedge clk) disable iff (srst) c_q.cs_f && c_q.cs_s[2] |-> lane_oe == 4'h0;
	endproperty
	a_float: assert property (p_float) else $error("lane driven while deselected");
	property p_standby;
		@(posedge clk) disable iff (srst) c_q.cs_f && !write_busy |=> standby;
	endproperty
	a_standby: assert property (p_standby) else $error("no standby when idle");
	property p_sector;
		@(posedge clk) disable iff (srst) cmd_valid |-> cmd_sector == cmd_addr[23:12];
	endproperty
	a_sector: assert property (p_sector) else $error("sector decode wrong");
	property p_block;
		@(posedge clk) disable iff (srst)
			cmd_valid |-> cmd_block == cmd_addr[23:16] && cmd_big_block == cmd_block[7:4];
	endproperty
	a_block: assert property (p_block) else $error("block decode wrong");
	property p_wp_off;
		@(posedge clk) disable iff (srst) quad_enable |=> wp_protect_n;
	endproperty
	a_wp_off: assert property (p_wp_off) else $error("protect active in quad");
	property p_quad_gate;
		@(posedge sclk) disable iff (frame_rst)
			r_q.st == sfb_pkg::ST_DOUT && r_q.lanes == sfb_pkg::LANES4 |-> c_q.qe;
	endproperty
	a_quad_gate: assert property (p_quad_gate) else $error("quad without enable");
	property p_dual_lanes;
		@(negedge sclk) disable iff (frame_rst) lane_oe == 4'h3 |->
			data_lanes(r_q.opc) == sfb_pkg::LANES2;
	endproperty
	a_dual_lanes: assert property (p_dual_lanes) else $error("dual on wrong opcode");
	sequence s_quad_addr_start;
		r_q.st == sfb_pkg::ST_ADDR && r_q.lanes == sfb_pkg::LANES4 && r_q.cnt == 6'h00;
	endsequence
	sequence s_quad_addr_end;
		##5 r_q.st == sfb_pkg::ST_ADDR ##1 r_q.st != sfb_pkg::ST_ADDR;
	endsequence
	property p_quad_addr;
		@(posedge sclk) disable iff (frame_rst) s_quad_addr_start |-> s_quad_addr_end;
	endproperty
	a_quad_addr: assert property (p_quad_addr) else $error("quad address not 6 clocks");

endmodule : sfb_frontend

`default_nettype wire

//--- dv/sfb_host.sv
`timescale 1ns/1ps
`default_nettype none

module sfb_host (
	output logic            sclk,
	output logic            cs_n,
	output logic      [3:0] lane_i,
	input  wire logic [3:0] lane_o,
	input  wire logic [3:0] lane_oe,
	input  wire logic       wp_level
);
	// ----------------------------------------------------------------
	// pin resolution
	// ----------------------------------------------------------------
	logic [3:0] h_o, h_oe, he, hv, oe_last, smp;
	logic [3:0] lastv = 4'h0;
	logic [7:0] rx[$];
	int         clash = 0, cnt, lim;
	bit         quadf;

	// starts low on purpose: the first frame checks that the device stays idle
	initial begin
		sclk = 1'b0;
		cs_n = 1'b0;
		h_o = 4'h0;
		h_oe = 4'h0;
		quadf = 1'b0;
	end

	// outside quad frames the protect pin is a host level, pause sits on its pull-up
	assign he = quadf ? h_oe : (h_oe | 4'h4);
	assign hv = quadf ? h_o : {h_o[3], wp_level, h_o[1:0]};
	// undriven lanes 0/1 toggle each clock so a stale value never passes
	assign lane_i = (lane_oe & lane_o) | (~lane_oe & he & hv) | (~lane_oe & ~he & {2'b11, ~lastv[1:0]});

	always @(posedge sclk) begin
		lastv <= lane_i;
		if (!cs_n && |(lane_oe & he)) clash <= clash + 1;
	end

	// ----------------------------------------------------------------
	// protocol tables
	// ----------------------------------------------------------------
	function automatic int alanes(input logic [7:0] op);
		case (op)
			8'hbb, 8'h92: return 2;
			8'heb, 8'he7, 8'h94: return 4;
			8'h03, 8'h0b, 8'h3b, 8'h6b, 8'h32, 8'h02, 8'h20, 8'h52, 8'hd8: return 1;
			default: return 0;
		endcase
	endfunction : alanes

	function automatic int dlanes(input logic [7:0] op);
		case (op)
			8'h03, 8'h0b: return 1;
			8'h3b, 8'hbb, 8'h92: return 2;
			8'h6b, 8'heb, 8'he7, 8'h94: return 4;
			default: return 0;
		endcase
	endfunction : dlanes

	function automatic int dummies(input logic [7:0] op);
		case (op)
			8'h0b, 8'h3b, 8'h6b: return 8;
			8'hbb, 8'h92, 8'he7: return 4;
			8'heb, 8'h94: return 6;
			default: return 0;
		endcase
	endfunction : dummies

	// ----------------------------------------------------------------
	// frame driver
	// ----------------------------------------------------------------
	// drive just after the falling edge, sample at the rising edge
	task automatic tick(input logic [3:0] v, input logic [3:0] e);
		if (cnt >= lim) return;
		cnt++;
		sclk = 1'b0;
		h_o = v;
		h_oe = e;
		#16;
		sclk = 1'b1;
		oe_last = lane_oe;
		smp = lane_i;
		#16;
	endtask : tick

	task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nb,
		input bit m3, input bit fresh, input int maxc);
		int n, k, j;
		logic [3:0] v;
		logic [7:0] b;
		cnt = 0;
		lim = maxc;
		quadf = (dlanes(op) == 4) || (op == 8'h32);
		if (fresh) cs_n = 1'b1;
		#250;
		sclk = m3;
		#20;
		cs_n = 1'b0;
		#20;
		for (k = 7; k >= 0; k--) tick({3'b000, op[k]}, 4'h1);
		n = alanes(op);
		for (k = 0; n > 0 && k < 24 / n; k++) begin
			v = 4'h0;
			for (j = 0; j < n; j++) v[j] = a[23 - k * n - (n - 1 - j)];
			tick(v, (4'h1 << n) - 4'h1);
		end
		for (k = 0; k < dummies(op); k++) tick(4'h0, 4'h0);
		n = dlanes(op);
		for (k = 0; n > 0 && k < nb; k++) begin
			b = 8'h00;
			for (j = 0; j < 8 / n; j++) begin
				tick(4'h0, 4'h0);
				if (n == 1) b = {b[6:0], smp[1]};
				else b = (b << n) | {4'h0, smp & ((4'h1 << n) - 4'h1)};
			end
			rx.push_back(b);
		end
		sclk = m3;
		#250;
		cs_n = 1'b1;
		quadf = 1'b0;
		#250;
	endtask : frame
endmodule : sfb_host

`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) \
	begin \
		cmp_count++; \
		if ((got) !== (ex)) begin \
			fails++; \
			$display("ERROR %s expected %0h seen %0h", nm, ex, got); \
		end \
	end

module tb;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clk = 1'b0, srst = 1'b1, por_active = 1'b0;
	logic        quad_enable = 1'b0, write_busy = 1'b0, wp_level = 1'b1;
	logic  [7:0] rd_byte = 8'h00;
	wire logic   sclk, cs_n, cmd_valid, sel_active, standby, wp_protect_n;
	wire logic [3:0] lane_i, lane_o, lane_oe, cmd_big_block;
	wire logic [7:0] cmd_opcode, cmd_block;
	wire logic [23:0] cmd_addr;
	wire logic [11:0] cmd_sector;
	wire logic [8:0] cmd_half_block;
	int          fails = 0, cmp_count = 0, seed, i, ad;
	logic  [7:0] op;
	logic [23:0] a;
	logic  [7:0] q_op[$];
	int          q_ad[$];
	logic  [7:0] ops[10] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h92, 8'h6b, 8'heb, 8'he7, 8'h94, 8'h32};

	always #25 clk = ~clk;

	sfb_host host_i (.sclk(sclk), .cs_n(cs_n), .lane_i(lane_i), .lane_o(lane_o),
		.lane_oe(lane_oe), .wp_level(wp_level));

	sfb_frontend sfb_frontend_i (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
		.lane_i(lane_i), .lane_o(lane_o), .lane_oe(lane_oe), .por_active(por_active),
		.quad_enable(quad_enable), .write_busy(write_busy), .rd_byte(rd_byte),
		.cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
		.cmd_sector(cmd_sector), .cmd_half_block(cmd_half_block), .cmd_block(cmd_block),
		.cmd_big_block(cmd_big_block), .sel_active(sel_active), .standby(standby),
		.wp_protect_n(wp_protect_n));

	// ----------------------------------------------------------------
	// header model
	// ----------------------------------------------------------------
	always @(negedge clk) begin
		if (cmd_valid === 1'b1) begin
			`CHK("cmd_expected", 1'b1, q_op.size() > 0)
			if (q_op.size() > 0) begin
				`CHK("cmd_opcode", q_op[0], cmd_opcode)
				ad = q_ad[0];
				if (ad >= 0) begin
					`CHK("cmd_addr", ad[23:0], cmd_addr)
					`CHK("cmd_sector", ad / 4096, cmd_sector)
					`CHK("cmd_half_block", ad / 32768, cmd_half_block)
					`CHK("cmd_block", ad / 65536, cmd_block)
					`CHK("cmd_big_block", ad / 1048576, cmd_big_block)
				end
				void'(q_op.pop_front());
				void'(q_ad.pop_front());
			end
		end
	end

	task automatic run(input logic [7:0] o, input logic [23:0] ar, input int nb,
		input bit m3, input bit fr, input int mc, input bit ok);
		int n;
		logic [3:0] m;
		n = ok ? host_i.dlanes(o) : 0;
		m = (n == 4) ? 4'hf : (n == 2) ? 4'h3 : (n == 1) ? 4'h2 : 4'h0;
		if (ok) begin
			q_op.push_back(o);
			q_ad.push_back(host_i.alanes(o) > 0 ? int'(ar) : -1);
		end
		host_i.rx.delete();
		host_i.frame(o, ar, nb, m3, fr, mc);
		`CHK("lane_oe_data", m, host_i.oe_last)
		`CHK("lane_oe_idle", 4'h0, lane_oe)
		`CHK("lane_clash", 0, host_i.clash)
		for (int k = 0; k < nb && n > 0; k++) begin
			`CHK("rd_data", rd_byte, host_i.rx[k])
		end
	endtask : run

	task automatic conclude();
		if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	// generous bound: the sequence needs well under a tenth of it
	initial begin
		#1000000;
		fails++;
		conclude();
	end

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'h33a1;
		repeat (16) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		run(8'h03, 24'h123456, 1, 0, 0, 999, 0);
		@(negedge clk) por_active = 1'b1;
		repeat (8) @(negedge clk);
		run(8'h03, 24'h000100, 1, 0, 1, 999, 0);
		@(negedge clk) por_active = 1'b0;
		repeat (8) @(negedge clk);
		for (i = 0; i < 20; i++) begin
			@(negedge clk);
			quad_enable = (i < 10);
			rd_byte = 8'($random(seed));
			a = (i == 0) ? 24'h000000 : (i == 1) ? 24'hffffff : 24'($random(seed));
			op = ops[i % 10];
			repeat (5) @(negedge clk);
			run(op, a, (op == 8'h32) ? 0 : 2, i[0], 1, 999,
				quad_enable || !(host_i.dlanes(op) == 4 || op == 8'h32));
		end
		a = 24'($random(seed));
		run(8'h0b, a, 0, 0, 1, 20, 0);
		run(8'h0b, a, 1, 1, 1, 999, 1);
		fork
			run(8'h0b, a, 2, 0, 1, 999, 0);
			begin
				#700;
				@(negedge clk) por_active = 1'b1;
				repeat (6) @(negedge clk);
				`CHK("sel_active_por", 1'b0, sel_active)
			end
		join
		@(negedge clk) por_active = 1'b0;
		@(negedge clk) write_busy = 1'b1;
		repeat (8) @(negedge clk);
		`CHK("standby_busy", 1'b0, standby)
		write_busy = 1'b0;
		repeat (8) @(negedge clk);
		`CHK("standby_idle", 1'b1, standby)
		fork
			run(8'h06, 24'h000000, 0, 0, 1, 999, 1);
			begin
				#600;
				`CHK("sel_active", 1'b1, sel_active)
				`CHK("standby_sel", 1'b0, standby)
			end
		join
		for (i = 0; i < 3; i++) begin
			@(negedge clk);
			quad_enable = (i == 1);
			wp_level = (i == 2);
			repeat (8) @(negedge clk);
			`CHK("wp_protect_n", wp_level | quad_enable, wp_protect_n)
		end
		repeat (10) @(negedge clk);
		`CHK("cmd_pending", 0, q_op.size())
		conclude();
	end
endmodule : tb

`default_nettype wire
